// ---- inc/bor_params.svh ----
// Offsets, field positions, reset values and timing counts of the reset controller
`ifndef BOR_PARAMS_SVH
`define BOR_PARAMS_SVH

// Register map (byte addresses on the plain register port)
`define BOR_ADDR_W 4
`define BOR_OFS_CONTROL 4'h0
`define BOR_OFS_EVT_STATUS 4'h1
`define BOR_OFS_EVT_MASK 4'h2

// Control register fields
`define BOR_SW_EN_BIT 7
`define BOR_READY_BIT 0
`define BOR_SW_EN_RST 1'b1

// Mode encodings
`define BOR_MODE_OFF 2'h0
`define BOR_MODE_SW 2'h1
`define BOR_MODE_AWAKE 2'h2
`define BOR_MODE_ON 2'h3

// Event status bits
`define BOR_EVT_W 4
`define BOR_EVT_BROWNOUT 0
`define BOR_EVT_RESET 1
`define BOR_EVT_READY 2
`define BOR_EVT_DIP 3

// Timing
`define BOR_CLK_MHZ 50
`define BOR_FILTER_NS 1000
`define BOR_FILTER_CYC ((`BOR_FILTER_NS * `BOR_CLK_MHZ + 999) / 1000)
`define BOR_PWRUP_MS 64
`define BOR_PWRUP_CYC (`BOR_PWRUP_MS * 1000 * `BOR_CLK_MHZ)
`define BOR_CNT_W 24

`endif

// ---- inc/bor_pkg.sv ----
// Types shared by the reset controller
package bor_pkg;

    typedef enum logic [1:0] {
        BOR_ST_HOLD,
        BOR_ST_PWRUP,
        BOR_ST_WAIT_RDY,
        BOR_ST_RUN
    } bor_state_t;

    typedef struct packed {
        logic por;
        logic brownout;
        logic low_power_brownout;
        logic external_clear_pin;
        logic watchdog;
        logic reset_instr;
        logic stack_overflow;
        logic stack_underflow;
        logic prog_exit;
        logic exec_violation_reset;
    } bor_src_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bor_req_t;

endpackage : bor_pkg

// ---- hw/bor_reset_ctrl.sv ----
// Reset controller: brown-out gating, power-up delay and reset source merging
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "bor_params.svh"
// Operation
// RQ1 - Core stays in reset while power-on detector reports supply too low.
// RQ2 - Ten reset sources accepted: POR, brown-outs, pin, watchdog, instruction, stack, exit, violation.
// RQ3 - Enabled power-up delay extends reset after power-on or brown-out.
// RQ4 - Mode 11: detector always on; start-up waits for ready and supply good.
// RQ5 - Mode 11: wake not delayed; ready already 1 before execution.
// RQ6 - Mode 10: detector on when awake, off in Sleep; start-up waits.
// RQ7 - Mode 10: no protection in Sleep; wake waits for detector ready.
// RQ8 - Mode 01: software enable switches detector; start-up does not wait.
// RQ9 - Software mode: protection once ready; Sleep does not change it.
// RQ10 - Mode 00: detector always off; start-up does not wait.
// RQ11 - Software enable at bit 7 always read/write; effective only in mode 01.
// RQ12 - Software enable resets to 1 on POR/brown-out, kept otherwise.
// RQ13 - Ready at bit 0 reads 1 while detector active, 0 otherwise.
// RQ14 - Bits 6 to 1 of control read zero and ignore writes.
// RQ15 - Brown-out reset only after supply low longer than filter time.
// RQ16 - Level select is passed through to the detector threshold.
// RQ17 - Low-power brown-out ORed with brown-out, same status flag.
// RQ18 - Reset asserted asynchronously, released synchronously after all sources clear.
module bor_reset_ctrl
    import bor_pkg::*;
#(
    parameter int PWRUP_CYC = `BOR_PWRUP_CYC
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Configuration
    input wire logic [1:0] i_brownout_mode_cfg,
    input wire logic [1:0] i_brownout_level_sel,
    input wire logic i_powerup_delay_timer_en,
    input wire logic i_sleep,
    // Analog detectors (asynchronous)
    input wire logic i_por_low,
    input wire logic i_supply_below_threshold,
    input wire logic i_detector_ready,
    input wire logic i_low_power_brownout,
    input wire logic i_external_clear_pin_n,
    // Digital reset requests (system clock)
    input wire logic i_watchdog_rst,
    input wire logic i_reset_instr,
    input wire logic i_stack_overflow,
    input wire logic i_stack_underflow,
    input wire logic i_prog_exit,
    input wire logic i_exec_violation_reset,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Outputs
    output logic o_detector_enable,
    output logic [1:0] o_brownout_level_sel,
    output logic o_core_reset_n,
    output logic o_cpu_run,
    output logic o_brownout_reset,
    output logic o_irq
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [1:0] por_s;
        logic [1:0] low_s;
        logic [1:0] rdy_s;
        logic [1:0] lp_s;
        logic [1:0] clr_s;
        logic sw_en;
        logic [`BOR_CNT_W-1:0] filt_cnt;
        logic [`BOR_CNT_W-1:0] pwr_cnt;
        bor_state_t st;
        logic [`BOR_EVT_W-1:0] evt;
        logic [`BOR_EVT_W-1:0] mask;
        logic rdy_q;
        logic [7:0] rdata;
        logic det_en;
        logic [1:0] lvl;
        logic run;
        logic bor;
        logic irq;
        logic prot_q;
    } bor_regs_t;

    localparam logic [`BOR_CNT_W-1:0] FILT_MAX = `BOR_CNT_W'(`BOR_FILTER_CYC);
    localparam logic [`BOR_CNT_W-1:0] PWR_MAX = `BOR_CNT_W'(PWRUP_CYC);

    bor_regs_t r_ff;
    bor_regs_t nxt_r;
    bor_src_t src;
    logic por_async;
    logic held_ff;
    logic held_sync_ff;
    logic core_rst_n_ff;

    logic por_low;
    logic sup_low;
    logic det_rdy;
    logic det_on;
    logic need_wait;
    logic brown_evt;
    logic dig_rst;
    logic wake_block;

    logic wr_ctl;
    logic wr_mask;
    logic rd_ctl;
    logic rd_status;
    logic rd_mask;

    // ************************************************************
    // Detector gating
    // ************************************************************
    always_comb begin
        por_low = r_ff.por_s[1];
        sup_low = r_ff.low_s[1];
        det_rdy = r_ff.rdy_s[1];

        case (i_brownout_mode_cfg)
            `BOR_MODE_ON: begin
                det_on = 1'b1; // RQ4
            end
            `BOR_MODE_AWAKE: begin
                det_on = ~i_sleep; // RQ6 RQ7
            end
            `BOR_MODE_SW: begin
                // Sleep does not touch the software-controlled state
                det_on = r_ff.sw_en; // RQ8 RQ9 RQ11
            end
            default: begin
                det_on = 1'b0; // RQ10
            end
        endcase

        // Start-up gated by detector only in the two hardware-on modes
        need_wait = i_brownout_mode_cfg[1]; // RQ4 RQ6 RQ8 RQ10

        // Mode 10 resumes only with the detector ready; mode 11 is always ready
        wake_block = (i_brownout_mode_cfg == `BOR_MODE_AWAKE)
            && !i_sleep
            && !det_rdy; // RQ5 RQ7

        // Main detector protection valid only once it reports ready; the low-power trip is not gated
        brown_evt = (det_on & det_rdy & (r_ff.filt_cnt >= FILT_MAX))
            | r_ff.lp_s[1]; // RQ9 RQ17

        dig_rst = i_watchdog_rst
            | i_reset_instr
            | i_stack_overflow
            | i_stack_underflow
            | i_prog_exit
            | i_exec_violation_reset
            | ~r_ff.clr_s[1]; // RQ2
    end

    always_comb begin
        src = '0;
        src.por = por_low;
        src.brownout = brown_evt;
        src.low_power_brownout = r_ff.lp_s[1];
        src.external_clear_pin = ~r_ff.clr_s[1];
        src.watchdog = i_watchdog_rst;
        src.reset_instr = i_reset_instr;
        src.stack_overflow = i_stack_overflow;
        src.stack_underflow = i_stack_underflow;
        src.prog_exit = i_prog_exit;
        src.exec_violation_reset = i_exec_violation_reset;
    end

    // ************************************************************
    // Register decode
    // ************************************************************
    // Upper address bits must be zero, so the map does not alias
    always_comb begin
        wr_ctl = i_wr && (i_addr == {4'h0, `BOR_OFS_CONTROL});
        wr_mask = i_wr && (i_addr == {4'h0, `BOR_OFS_EVT_MASK});
        rd_ctl = i_rd && (i_addr == {4'h0, `BOR_OFS_CONTROL});
        rd_status = i_rd && (i_addr == {4'h0, `BOR_OFS_EVT_STATUS});
        rd_mask = i_rd && (i_addr == {4'h0, `BOR_OFS_EVT_MASK});
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        nxt_r = r_ff;
        nxt_r.por_s = {r_ff.por_s[0], i_por_low};
        nxt_r.low_s = {r_ff.low_s[0], i_supply_below_threshold};
        nxt_r.rdy_s = {r_ff.rdy_s[0], i_detector_ready};
        nxt_r.lp_s = {r_ff.lp_s[0], i_low_power_brownout};
        nxt_r.clr_s = {r_ff.clr_s[0], i_external_clear_pin_n};
        nxt_r.det_en = det_on;
        nxt_r.lvl = i_brownout_level_sel; // RQ16
        nxt_r.rdy_q = det_rdy;

        // ********************************************************
        // Dip filter
        // ********************************************************
        // Short dips restart the count; the count saturates so a long
        // dip keeps the brown-out asserted until the supply recovers
        if (det_on && sup_low) begin // RQ15
            if (r_ff.filt_cnt < FILT_MAX) begin
                nxt_r.filt_cnt = r_ff.filt_cnt + `BOR_CNT_W'(1);
            end
        end else begin
            nxt_r.filt_cnt = '0;
        end

        // ********************************************************
        // Start-up sequencer
        // ********************************************************
        case (r_ff.st)
            BOR_ST_HOLD: begin
                nxt_r.run = 1'b0;
                nxt_r.pwr_cnt = '0;
                if (!por_low && !brown_evt) begin // RQ1
                    if (i_powerup_delay_timer_en) begin
                        nxt_r.st = BOR_ST_PWRUP;
                    end else begin
                        nxt_r.st = BOR_ST_WAIT_RDY;
                    end
                end
            end
            BOR_ST_PWRUP: begin
                nxt_r.run = 1'b0;
                nxt_r.pwr_cnt = r_ff.pwr_cnt + `BOR_CNT_W'(1); // RQ3
                if (r_ff.pwr_cnt >= PWR_MAX - `BOR_CNT_W'(1)) begin
                    nxt_r.st = BOR_ST_WAIT_RDY;
                end
            end
            BOR_ST_WAIT_RDY: begin
                nxt_r.run = 1'b0;
                // Modes 00 and 01 start at once, whatever the detector says
                if (!need_wait || (det_rdy && !sup_low)) begin // RQ4 RQ6
                    nxt_r.st = BOR_ST_RUN;
                end
            end
            BOR_ST_RUN: begin
                nxt_r.run = ~dig_rst & ~wake_block; // RQ5 RQ7
            end
            default: begin
                nxt_r.run = 1'b0;
                nxt_r.st = BOR_ST_HOLD;
            end
        endcase

        // Power-on and brown-out always restart the whole sequence
        if (por_low || brown_evt) begin // RQ1 RQ3
            nxt_r.st = BOR_ST_HOLD;
            nxt_r.run = 1'b0;
        end
        nxt_r.bor = brown_evt; // RQ17
        nxt_r.prot_q = brown_evt;

        // ********************************************************
        // Register writes
        // ********************************************************
        // Software enable returns to 1 only on power-on, brown-out or i_reset_n
        if (por_low || brown_evt) begin
            nxt_r.sw_en = `BOR_SW_EN_RST; // RQ12
        end else if (wr_ctl) begin
            nxt_r.sw_en = i_wdata[`BOR_SW_EN_BIT]; // RQ11 RQ14
        end

        if (wr_mask) begin
            nxt_r.mask = i_wdata[`BOR_EVT_W-1:0];
        end

        // ********************************************************
        // Read data, one cycle later, zero otherwise
        // ********************************************************
        nxt_r.rdata = 8'h00;
        if (rd_ctl) begin
            nxt_r.rdata[`BOR_SW_EN_BIT] = r_ff.sw_en; // RQ11
            nxt_r.rdata[`BOR_READY_BIT] = det_rdy & det_on; // RQ13 RQ14
        end else if (rd_status) begin
            nxt_r.rdata = {4'h0, r_ff.evt};
        end else if (rd_mask) begin
            nxt_r.rdata = {4'h0, r_ff.mask};
        end

        // ********************************************************
        // Sticky events
        // ********************************************************
        // Read clears first, so an event in the same cycle wins
        if (rd_status) begin
            nxt_r.evt = '0;
        end
        if (brown_evt && !r_ff.prot_q) begin
            nxt_r.evt[`BOR_EVT_BROWNOUT] = 1'b1; // RQ17
        end
        if ((dig_rst || por_low) && r_ff.run) begin
            nxt_r.evt[`BOR_EVT_RESET] = 1'b1;
        end
        if (det_rdy && !r_ff.rdy_q) begin
            nxt_r.evt[`BOR_EVT_READY] = 1'b1;
        end
        if (det_on && sup_low && r_ff.filt_cnt == '0) begin
            nxt_r.evt[`BOR_EVT_DIP] = 1'b1;
        end

        // Level interrupt follows the stored events, not the raw ones
        nxt_r.irq = |(nxt_r.evt & nxt_r.mask);
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            r_ff <= '0;
            r_ff.sw_en <= `BOR_SW_EN_RST;
            r_ff.clr_s <= 2'b11;
            r_ff.st <= BOR_ST_HOLD;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ************************************************************
    // Core reset: asynchronous assert, synchronous release
    // ************************************************************
    // Held state combines registered detector sources with the unregistered digital reset inputs
    assign por_async = |src | (r_ff.st != BOR_ST_RUN);

    always_ff @(posedge i_clock or posedge por_async) begin
        if (por_async) begin // RQ18
            held_ff <= 1'b0;
            held_sync_ff <= 1'b0;
            core_rst_n_ff <= 1'b0;
        end else begin
            held_ff <= 1'b1;
            held_sync_ff <= held_ff;
            core_rst_n_ff <= held_sync_ff & i_reset_n; // RQ18
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign o_core_reset_n = core_rst_n_ff;
    assign o_rdata = r_ff.rdata;
    assign o_detector_enable = r_ff.det_en;
    assign o_brownout_level_sel = r_ff.lvl;
    assign o_cpu_run = r_ff.run;
    assign o_brownout_reset = r_ff.bor;
    assign o_irq = r_ff.irq;

endmodule : bor_reset_ctrl

// ---- dv/bor_reset_ctrl_chk.sv ----
// Port checker of the reset controller
`timescale 1ns/1ps
`include "bor_params.svh"
module bor_reset_ctrl_chk (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic [1:0] i_brownout_mode_cfg,
    input wire logic [1:0] i_brownout_level_sel,
    input wire logic i_sleep,
    input wire logic i_por_low,
    input wire logic i_supply_below_threshold,
    input wire logic i_low_power_brownout,
    input wire logic i_watchdog_rst,
    input wire logic [7:0] i_addr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic o_detector_enable,
    input wire logic [1:0] o_brownout_level_sel,
    input wire logic o_core_reset_n,
    input wire logic o_brownout_reset
);
    // ************
    // Assertions
    // ************
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    int low_cnt_ff = 0;
    always_ff @(posedge i_clock) begin
        low_cnt_ff <= i_supply_below_threshold ? low_cnt_ff + 1 : 0;
    end
    sequence rd_ctl_s; $past(i_rd) && $past(i_addr) == 8'h00; endsequence
    sequence por_low_s; i_por_low [*4]; endsequence
    sequence lp_trip_s; i_low_power_brownout [*4]; endsequence
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not idle");
    ctl_gaps_a: assert property (rd_ctl_s |-> o_rdata[6:1] == 6'h00)
        else $error("unused control bits not zero");
    level_pass_a: assert property ($past(i_reset_n)
        |-> o_brownout_level_sel == $past(i_brownout_level_sel))
        else $error("level select not passed");
    mode_off_a: assert property (i_brownout_mode_cfg == 2'h0 |=> !o_detector_enable)
        else $error("detector on in off mode");
    mode_on_a: assert property (i_brownout_mode_cfg == 2'h3 |=> o_detector_enable)
        else $error("detector off in always-on mode");
    sleep_off_a: assert property (i_brownout_mode_cfg == 2'h2 && i_sleep
        |=> !o_detector_enable)
        else $error("detector on in sleep");
    wdog_rst_a: assert property (i_watchdog_rst |-> ##[0:3] !o_core_reset_n)
        else $error("watchdog did not reset core");
    por_hold_a: assert property (por_low_s |-> !o_core_reset_n)
        else $error("core ran with supply low");
    lp_merge_a: assert property (lp_trip_s |-> ##[0:2] o_brownout_reset)
        else $error("low-power trip not merged");
    dip_filter_a: assert property ($rose(o_brownout_reset) |->
        low_cnt_ff >= `BOR_FILTER_CYC || i_low_power_brownout)
        else $error("brown-out reset on short dip");
endmodule : bor_reset_ctrl_chk

bind bor_reset_ctrl bor_reset_ctrl_chk chk_u (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_brownout_mode_cfg(i_brownout_mode_cfg), .i_brownout_level_sel(i_brownout_level_sel),
    .i_sleep(i_sleep), .i_por_low(i_por_low), .i_watchdog_rst(i_watchdog_rst),
    .i_supply_below_threshold(i_supply_below_threshold), .i_addr(i_addr), .i_rd(i_rd),
    .i_low_power_brownout(i_low_power_brownout), .o_rdata(o_rdata),
    .o_detector_enable(o_detector_enable), .o_brownout_level_sel(o_brownout_level_sel),
    .o_core_reset_n(o_core_reset_n), .o_brownout_reset(o_brownout_reset));

// ---- dv/bor_supply_model.sv ----
// Behavioural model of the supply detectors
`timescale 1ns/1ps
module bor_supply_model #(
    parameter int READY_DLY = 8
) (
    input wire logic i_clock,
    input wire logic i_detector_enable,
    input wire logic i_supply_low,
    output logic o_detector_ready,
    output logic o_supply_below
);
    // ************
    // Detector
    // ************
    int cnt_ff = 0;
    // Ready only after a settling time, so start-up waits are visible
    always @(posedge i_clock) begin
        cnt_ff <= i_detector_enable ? cnt_ff + 1 : 0;
    end
    assign o_detector_ready = cnt_ff > READY_DLY;
    assign o_supply_below = i_supply_low;
endmodule : bor_supply_model

// ---- dv/brownout_reset_control_test.sv ----
// Self-checking bench of the reset controller
`timescale 1ns/1ps
module brownout_reset_control_test;
    // ************
    // Stimulus
    // ************
    logic i_clock = 1'b0, i_reset_n = 1'b0, pwr_en = 1'b1, sleep = 1'b0, por_low = 1'b1;
    logic sup_low = 1'b0, lp = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [1:0] mode = 2'h3, lvl = 2'h2, lvl_o;
    logic [6:0] src = 7'h00;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rdv;
    logic rdy, below, det_en, core_n, run, bo_rst, irq;
    logic [4:0] obs;
    assign obs = {det_en, irq, bo_rst, core_n, run};
    int n_fail = 0, checks_done = 0, cyc = 0, n;
    initial forever #10 i_clock = ~i_clock;
    bor_supply_model model_u (.i_clock(i_clock), .i_detector_enable(det_en),
        .i_supply_low(sup_low), .o_detector_ready(rdy), .o_supply_below(below));
    bor_reset_ctrl #(.PWRUP_CYC(20)) dut_u (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_brownout_mode_cfg(mode), .i_brownout_level_sel(lvl), .i_powerup_delay_timer_en(pwr_en),
        .i_sleep(sleep), .i_por_low(por_low), .i_supply_below_threshold(below),
        .i_detector_ready(rdy), .i_low_power_brownout(lp), .i_external_clear_pin_n(!src[6]),
        .i_watchdog_rst(src[0]), .i_reset_instr(src[1]), .i_stack_overflow(src[2]),
        .i_stack_underflow(src[3]), .i_prog_exit(src[4]), .i_exec_violation_reset(src[5]),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_detector_enable(det_en), .o_brownout_level_sel(lvl_o), .o_core_reset_n(core_n),
        .o_cpu_run(run), .o_brownout_reset(bo_rst), .o_irq(irq));
    task automatic tally_and_finish;
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // Generous ceiling: the sequence needs a few hundred cycles
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clock);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp,
        input string nm);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clock);
        rd <= 1'b0;
        #1 chk(nm, exp, rdata & m);
        @(posedge i_clock);
    endtask : rd_chk
    task automatic wait_run(input int lim);
        n = 0;
        while (run !== 1'b1 && n < lim) begin
            @(posedge i_clock);
            n++;
        end
        chk("run_up", 8'h01, {7'h0, run});
    endtask : wait_run
    // Samples mid-cycle, then hands back on a rising edge
    task automatic bit_after(input int k, input string nm, input logic exp, input int sel);
        repeat (k - 1) @(posedge i_clock);
        @(negedge i_clock);
        chk(nm, {7'h0, exp}, {7'h0, obs[sel]});
        @(posedge i_clock);
    endtask : bit_after
    task automatic do_reset(input logic [1:0] m);
        i_reset_n <= 1'b0;
        mode <= m;
        por_low <= 1'b1;
        repeat (16) @(posedge i_clock);
        i_reset_n <= 1'b1;
        bit_after(6, "core_por", 1'b0, 1);
        por_low <= 1'b0;
        wait_run(300);
    endtask : do_reset
    initial begin
        do_reset(2'h3);
        chk("pwrup", 8'h01, {7'h0, n >= 20});
        rd_chk(8'h00, 8'hFF, 8'h81, "ctl_on");
        chk("lvl", {6'h0, lvl}, {6'h0, lvl_o});
        wr_reg(8'h00, 8'h7E);
        rd_chk(8'h00, 8'hFF, 8'h01, "ctl_wr");
        rd_chk(8'h0F, 8'hFF, 8'h00, "unmapped");
        rd_chk(8'h02, 8'hFF, 8'h00, "mask_rst");
        sup_low <= 1'b1;
        repeat (30) @(posedge i_clock);
        sup_low <= 1'b0;
        bit_after(5, "short_dip", 1'b0, 2);
        chk("irq_masked", 8'h00, {7'h0, irq});
        wr_reg(8'h02, 8'h08);
        bit_after(3, "irq_on", 1'b1, 3);
        rd_chk(8'h01, 8'h08, 8'h08, "dip_evt");
        bit_after(2, "irq_clr", 1'b0, 3);
        rd_chk(8'h01, 8'h08, 8'h00, "evt_clr");
        sup_low <= 1'b1;
        bit_after(80, "long_dip", 1'b1, 2);
        chk("dip_core", 8'h00, {7'h0, core_n});
        sup_low <= 1'b0;
        wait_run(300);
        rd_chk(8'h00, 8'hFF, 8'h81, "sw_en_bor");
        rd_chk(8'h01, 8'h01, 8'h01, "bor_evt");
        for (int k = 0; k < 7; k++) begin
            src <= 7'h01 << k;
            bit_after(6, "src_rst", 1'b0, 1);
            src <= 7'h00;
            wait_run(300);
            chk("src_back", 8'h01, {7'h0, run});
        end
        lp <= 1'b1;
        bit_after(8, "low_power_brownout", 1'b1, 2);
        lp <= 1'b0;
        wait_run(300);
        rd_chk(8'h01, 8'h01, 8'h01, "lp_evt");
        sup_low <= 1'b1;
        do_reset(2'h0);
        chk("off_run", 8'h01, {7'h0, run});
        sup_low <= 1'b0;
        do_reset(2'h1);
        sleep <= 1'b1;
        bit_after(3, "sw_sleep", 1'b1, 4);
        sleep <= 1'b0;
        wr_reg(8'h00, 8'h00);
        bit_after(3, "sw_off", 1'b0, 4);
        do_reset(2'h2);
        sleep <= 1'b1;
        bit_after(3, "awake_sleep", 1'b0, 4);
        sleep <= 1'b0;
        bit_after(3, "awake_on", 1'b1, 4);
        tally_and_finish();
    end
endmodule : brownout_reset_control_test
